//--- include/mcl_pkg.sv
// package: widths, defaults, timing and types of the motor command limiter
package mcl_pkg;

    // ----------------------------------------
    // clock and pwm sampling
    // ----------------------------------------
    localparam int CLK_HZ         = 50_000_000;
    localparam int PWM_SAMPLE_HZ  = 1_000_000;
    localparam int PWM_DIV        = CLK_HZ / PWM_SAMPLE_HZ;
    localparam int PWM_WIN_BITS   = 10;              // 1024 samples per duty frame
    localparam int DUTY_W         = PWM_WIN_BITS + 1;

    // ----------------------------------------
    // widths and scaling
    // ----------------------------------------
    localparam int SPD_W          = 12;              // r/min
    localparam int TRQ_W          = 8;               // percent
    localparam int VOLT_W         = 14;              // 1/1024 V per lsb
    localparam int VOLT_FRAC      = 10;
    localparam int SUM_W          = 18;
    localparam int DOUT_N         = 4;

    // ----------------------------------------
    // defaults and full scales
    // ----------------------------------------
    localparam logic [SPD_W-1:0] SPD_UPPER_DEF = 12'hC4E;   // 3150
    localparam logic [SPD_W-1:0] SPD_LOWER_DEF = 12'h050;   // 80
    localparam logic [TRQ_W-1:0] TRQ_MAX_DEF   = 8'hC8;     // 200
    localparam logic [SPD_W-1:0] SPD_GAIN_DEF  = 12'h280;   // 640
    localparam logic [TRQ_W-1:0] TRQ_GAIN_DEF  = 8'h2B;     // 43
    localparam logic [SPD_W-1:0] SPD_FULL      = 12'hC4E;   // pwm 100 % speed
    localparam logic [TRQ_W-1:0] TRQ_FULL      = 8'hC8;     // pwm 100 % torque

    // ----------------------------------------
    // digital output functions
    // ----------------------------------------
    typedef enum logic [3:0] {
        FN_NOT_USED, FN_ALARM_A, FN_ALARM_NC, FN_MOVE, FN_INFO, FN_TRQ_LIMITING,
        FN_VA, FN_SPEED_OUT, FN_DIR, FN_SPD_CLAMP, FN_TRQ_CLAMP
    } mcl_dout_fn_t;
    localparam int FN_COUNT = 11;

    typedef struct packed {
        logic [SPD_W-1:0]          spd_upper;   // class B
        logic [SPD_W-1:0]          spd_lower;   // class B
        logic [TRQ_W-1:0]          trq_max;     // class B
        logic                      ext_pwm;     // class C
        logic [SPD_W-1:0]          spd_gain;    // class A
        logic signed [SPD_W-1:0]   spd_ofs;     // class A
        logic [TRQ_W-1:0]          trq_gain;    // class A
        logic signed [TRQ_W-1:0]   trq_ofs;     // class A
        mcl_dout_fn_t [DOUT_N-1:0] dout_func;   // class C
        logic [DOUT_N-1:0]         dout_inv;    // class C
    } mcl_cfg_t;

    localparam mcl_cfg_t CFG_DEF = '{
        spd_upper: SPD_UPPER_DEF,
        spd_lower: SPD_LOWER_DEF,
        trq_max:   TRQ_MAX_DEF,
        ext_pwm:   1'b0,
        spd_gain:  SPD_GAIN_DEF,
        spd_ofs:   12'h000,
        trq_gain:  TRQ_GAIN_DEF,
        trq_ofs:   8'h00,
        dout_func: '{FN_DIR, FN_TRQ_LIMITING, FN_ALARM_NC, FN_SPEED_OUT},
        dout_inv:  4'h0
    };

endpackage : mcl_pkg

//--- src/mcl_pwm_duty.sv
// pwm duty meter: synchronised pin sampled at a fixed rate over a fixed frame
`timescale 1ns/1ps
`default_nettype none
module mcl_pwm_duty
    import mcl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              pwm_pin,
    output logic [DUTY_W-1:0]      duty      // high samples per 1024
);
    logic                    sync1_ff, sync2_ff;
    logic [7:0]              div_ff, nxt_div;
    logic [PWM_WIN_BITS-1:0] smp_ff, nxt_smp;
    logic [DUTY_W-1:0]       acc_ff, nxt_acc, duty_ff, nxt_duty;
    logic                    tick;

    always_comb begin
        tick     = (div_ff == 8'(PWM_DIV - 1));
        nxt_div  = tick ? 8'h00 : div_ff + 8'h01;
        nxt_smp  = smp_ff;
        nxt_acc  = acc_ff;
        nxt_duty = duty_ff;
        if (tick) begin
            nxt_smp = smp_ff + PWM_WIN_BITS'(1'b1);
            nxt_acc = acc_ff + DUTY_W'(sync2_ff);
            if (smp_ff == '1) begin
                nxt_duty = acc_ff + DUTY_W'(sync2_ff);
                nxt_acc  = '0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            div_ff   <= 8'h00;
            smp_ff   <= '0;
            acc_ff   <= '0;
            duty_ff  <= '0;
        end else begin
            sync1_ff <= pwm_pin;
            sync2_ff <= sync1_ff;
            div_ff   <= nxt_div;
            smp_ff   <= nxt_smp;
            acc_ff   <= nxt_acc;
            duty_ff  <= nxt_duty;
        end
    end

    assign duty = duty_ff;

    a_duty_range: assert property (@(posedge clk) disable iff (rst)
        duty_ff <= DUTY_W'(1 << PWM_WIN_BITS)) else $error("duty above full frame");
endmodule : mcl_pwm_duty
`default_nettype wire

//--- src/mcl_dout_map.sv
// digital output mapper: per output function select and optional inversion
`timescale 1ns/1ps
`default_nettype none
module mcl_dout_map
    import mcl_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire mcl_dout_fn_t [DOUT_N-1:0] func,
    input  wire logic [DOUT_N-1:0]         inv,
    input  wire logic [FN_COUNT-1:0]       status,
    output logic [DOUT_N-1:0]              dout
);
    logic [DOUT_N-1:0] dout_ff, nxt_dout;

    for (genvar i = 0; i < DOUT_N; i++) begin : g_out
        always_comb begin
            nxt_dout[i] = status[func[i]] ^ inv[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_ff <= '0;
        end else begin
            dout_ff <= nxt_dout;
        end
    end

    assign dout = dout_ff;

    a_dout_polarity: assert property (@(posedge clk) disable iff (rst)
        ##1 dout_ff[0] == ($past(status[func[0]]) ^ $past(inv[0])))
        else $error("output 0 level not function xor invert");
endmodule : mcl_dout_map
`default_nettype wire

//--- src/mcl_limiter.sv
// motor command limiter: class-gated settings, command scaling, clamping, output mapping
// What this block does
// - speed upper limit setting, 80 to 3150 r/min, default 3150.
// - speed lower limit setting, 80 to 3150 r/min, default 80.
// - speed above upper limit runs at the upper limit.
// - speed below lower limit runs at the lower limit.
// - any speed clamp raises the speed clamp information flag.
// - torque limit maximum setting, 0 to 200 percent, default 200.
// - torque limit above maximum is replaced by the maximum.
// - torque clamp to maximum raises the torque clamp information flag.
// - external source is analog or pwm, analog by default.
// - with pwm selected, command follows the measured input duty cycle.
// - analog speed gain 0 to 3150 r/min per volt, default 640.
// - analog speed offset of plus or minus 1500 r/min, default 0.
// - analog torque gain 0 to 200 percent per volt, default 43.
// - analog torque offset of plus or minus 100 percent, default 0.
// - class A applies now, B when stopped, C on configuration execute.
// - four outputs with selectable functions, defaults speed, alarm nc, limiting, dir.
// - each output can be inverted, not inverted by default.
`timescale 1ns/1ps
`default_nettype none
module mcl_limiter
    import mcl_pkg::*;
(
    input  wire logic               CLOCK_IN,
    input  wire logic               RST_IN,
    input  wire mcl_cfg_t           CFG_IN,
    input  wire logic               MOTOR_STOPPED_IN,
    input  wire logic               CFG_EXEC_IN,
    input  wire logic               EXT_SPD_SEL_IN,
    input  wire logic               EXT_TRQ_SEL_IN,
    input  wire logic [SPD_W-1:0]   OP_SPEED_IN,
    input  wire logic [TRQ_W-1:0]   OP_TORQUE_IN,
    input  wire logic [VOLT_W-1:0]  ANALOG_SPD_IN,
    input  wire logic [VOLT_W-1:0]  ANALOG_TRQ_IN,
    input  wire logic               PWM_IN,
    input  wire logic               ALARM_IN,
    input  wire logic               MOVE_IN,
    input  wire logic               INFO_IN,
    input  wire logic               VA_IN,
    input  wire logic               SPEED_PULSE_IN,
    input  wire logic               DIR_IN,
    input  wire logic               TORQUE_LIMITING_ACTIVE_IN,
    output logic [SPD_W-1:0]        SPEED_CMD_OUT,
    output logic [TRQ_W-1:0]        TORQUE_CMD_OUT,
    output logic                    SPEED_CLAMP_INFO_OUT,
    output logic                    TORQUE_CLAMP_INFO_OUT,
    output logic                    DIGITAL_OUT_0_OUT,
    output logic                    DIGITAL_OUT_1_OUT,
    output logic                    DIGITAL_OUT_2_OUT,
    output logic                    DIGITAL_OUT_3_OUT,
    output logic                    ACTIVE_EXT_PWM_OUT
);

    // ----------------------------------------
    // settings held in force
    // ----------------------------------------
    mcl_cfg_t cfg_ff, nxt_cfg;

    // class A fields always follow; B and C wait for their own trigger so a
    // running motor never sees its limits move under it
    always_comb begin
        nxt_cfg          = cfg_ff;
        nxt_cfg.spd_gain = CFG_IN.spd_gain;
        nxt_cfg.spd_ofs  = CFG_IN.spd_ofs;
        nxt_cfg.trq_gain = CFG_IN.trq_gain;
        nxt_cfg.trq_ofs  = CFG_IN.trq_ofs;
        if (MOTOR_STOPPED_IN) begin
            nxt_cfg.spd_upper = CFG_IN.spd_upper;
            nxt_cfg.spd_lower = CFG_IN.spd_lower;
            nxt_cfg.trq_max   = CFG_IN.trq_max;
        end
        if (CFG_EXEC_IN) begin
            nxt_cfg.ext_pwm   = CFG_IN.ext_pwm;
            nxt_cfg.dout_func = CFG_IN.dout_func;
            nxt_cfg.dout_inv  = CFG_IN.dout_inv;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cfg_ff <= CFG_DEF;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // ----------------------------------------
    // pwm duty measurement
    // ----------------------------------------
    logic [DUTY_W-1:0] duty;

    mcl_pwm_duty u_pwm (
        .clk     (CLOCK_IN),
        .rst     (RST_IN),
        .pwm_pin (PWM_IN),
        .duty    (duty)
    );

    // ----------------------------------------
    // command scaling
    // ----------------------------------------
    logic [SPD_W+VOLT_W-1:0]  spd_prod;
    logic [TRQ_W+VOLT_W-1:0]  trq_prod;
    logic [SPD_W+DUTY_W-1:0]  spd_pwm_prod;
    logic [TRQ_W+DUTY_W-1:0]  trq_pwm_prod;
    logic signed [SUM_W-1:0]  spd_analog, trq_analog, spd_raw, trq_raw;
    logic signed [SUM_W-1:0]  spd_pwm, trq_pwm;

    always_comb begin
        spd_prod     = cfg_ff.spd_gain * ANALOG_SPD_IN;
        trq_prod     = cfg_ff.trq_gain * ANALOG_TRQ_IN;
        spd_pwm_prod = SPD_FULL * duty;
        trq_pwm_prod = TRQ_FULL * duty;
        // gain is per volt and the voltage carries ten fraction bits
        spd_analog = $signed(SUM_W'(spd_prod[SPD_W+VOLT_W-1:VOLT_FRAC]))
                   + SUM_W'(cfg_ff.spd_ofs);
        trq_analog = $signed(SUM_W'(trq_prod[TRQ_W+VOLT_W-1:VOLT_FRAC]))
                   + SUM_W'(cfg_ff.trq_ofs);
        spd_pwm    = $signed(SUM_W'(spd_pwm_prod[SPD_W+DUTY_W-1:PWM_WIN_BITS]));
        trq_pwm    = $signed(SUM_W'(trq_pwm_prod[TRQ_W+DUTY_W-1:PWM_WIN_BITS]));
        if (!EXT_SPD_SEL_IN) begin
            spd_raw = $signed(SUM_W'(OP_SPEED_IN));
        end else if (cfg_ff.ext_pwm) begin
            spd_raw = spd_pwm;
        end else begin
            spd_raw = spd_analog;
        end
        if (!EXT_TRQ_SEL_IN) begin
            trq_raw = $signed(SUM_W'(OP_TORQUE_IN));
        end else if (cfg_ff.ext_pwm) begin
            trq_raw = trq_pwm;
        end else begin
            trq_raw = trq_analog;
        end
    end

    // ----------------------------------------
    // clamping and information flags
    // ----------------------------------------
    logic [SPD_W-1:0] spd_ff, nxt_spd;
    logic [TRQ_W-1:0] trq_ff, nxt_trq;
    logic             spd_info_ff, nxt_spd_info;
    logic             trq_info_ff, nxt_trq_info;
    logic signed [SUM_W-1:0] upper_s, lower_s, tmax_s;

    // the upper limit is tested first, so a lower limit set above it still
    // raises a command at or below the ceiling past it
    always_comb begin
        upper_s      = $signed(SUM_W'(cfg_ff.spd_upper));
        lower_s      = $signed(SUM_W'(cfg_ff.spd_lower));
        tmax_s       = $signed(SUM_W'(cfg_ff.trq_max));
        nxt_spd      = spd_raw[SPD_W-1:0];
        nxt_spd_info = 1'b0;
        if (spd_raw > upper_s) begin
            nxt_spd      = cfg_ff.spd_upper;
            nxt_spd_info = 1'b1;
        end else if (spd_raw < lower_s) begin
            nxt_spd      = cfg_ff.spd_lower;
            nxt_spd_info = 1'b1;
        end
        nxt_trq      = trq_raw[TRQ_W-1:0];
        nxt_trq_info = 1'b0;
        if (trq_raw > tmax_s) begin
            nxt_trq      = cfg_ff.trq_max;
            nxt_trq_info = 1'b1;
        end else if (trq_raw[SUM_W-1]) begin
            // a negative offset result is floored silently at zero torque
            nxt_trq = '0;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            spd_ff      <= '0;
            trq_ff      <= '0;
            spd_info_ff <= 1'b0;
            trq_info_ff <= 1'b0;
        end else begin
            spd_ff      <= nxt_spd;
            trq_ff      <= nxt_trq;
            spd_info_ff <= nxt_spd_info;
            trq_info_ff <= nxt_trq_info;
        end
    end

    // ----------------------------------------
    // digital outputs
    // ----------------------------------------
    logic [FN_COUNT-1:0] status;
    logic [DOUT_N-1:0]   dout;

    always_comb begin
        status                  = '0;
        status[FN_ALARM_A]      = ALARM_IN;
        status[FN_ALARM_NC]     = ~ALARM_IN;
        status[FN_MOVE]         = MOVE_IN;
        status[FN_INFO]         = INFO_IN | spd_info_ff | trq_info_ff;
        status[FN_TRQ_LIMITING] = TORQUE_LIMITING_ACTIVE_IN;
        status[FN_VA]           = VA_IN;
        status[FN_SPEED_OUT]    = SPEED_PULSE_IN;
        status[FN_DIR]          = DIR_IN;
        status[FN_SPD_CLAMP]    = spd_info_ff;
        status[FN_TRQ_CLAMP]    = trq_info_ff;
    end

    mcl_dout_map u_dout (
        .clk    (CLOCK_IN),
        .rst    (RST_IN),
        .func   (cfg_ff.dout_func),
        .inv    (cfg_ff.dout_inv),
        .status (status),
        .dout   (dout)
    );

    assign SPEED_CMD_OUT         = spd_ff;
    assign TORQUE_CMD_OUT        = trq_ff;
    assign SPEED_CLAMP_INFO_OUT  = spd_info_ff;
    assign TORQUE_CLAMP_INFO_OUT = trq_info_ff;
    assign DIGITAL_OUT_0_OUT     = dout[0];
    assign DIGITAL_OUT_1_OUT     = dout[1];
    assign DIGITAL_OUT_2_OUT     = dout[2];
    assign DIGITAL_OUT_3_OUT     = dout[3];
    assign ACTIVE_EXT_PWM_OUT    = cfg_ff.ext_pwm;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_reset_defaults: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        $past(RST_IN) |-> (cfg_ff.spd_upper == SPD_UPPER_DEF
            && cfg_ff.spd_lower == SPD_LOWER_DEF && cfg_ff.trq_max == TRQ_MAX_DEF))
        else $error("settings not at defaults after reset");

    a_spd_upper_cap: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (spd_raw > upper_s) |=> (spd_ff == $past(cfg_ff.spd_upper)))
        else $error("speed not capped at upper limit");

    a_spd_lower_floor: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (spd_raw < lower_s && spd_raw <= upper_s) |=> (spd_ff == $past(cfg_ff.spd_lower)))
        else $error("speed not raised to lower limit");

    a_spd_flag_tie: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        ##1 spd_info_ff == ($past(spd_raw > upper_s) || $past(spd_raw < lower_s)))
        else $error("speed clamp flag disagrees with clamp");

    a_trq_cap: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (trq_raw > tmax_s) |=> (trq_ff == $past(cfg_ff.trq_max) && trq_info_ff))
        else $error("torque not capped at maximum");

    a_trq_flag_clear: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (trq_raw <= tmax_s) |=> !trq_info_ff)
        else $error("torque clamp flag without clamp");

    a_class_b_hold: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        !MOTOR_STOPPED_IN |=> $stable(cfg_ff.spd_upper) && $stable(cfg_ff.trq_max))
        else $error("class B setting moved while running");

    a_class_c_hold: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        !CFG_EXEC_IN |=> $stable(cfg_ff.ext_pwm) && $stable(cfg_ff.dout_inv))
        else $error("class C setting moved without execute");

    a_class_a_follow: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        ##1 cfg_ff.spd_gain == $past(CFG_IN.spd_gain))
        else $error("class A gain not applied at once");

    a_analog_scale: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (EXT_SPD_SEL_IN && !cfg_ff.ext_pwm && spd_analog >= lower_s
            && spd_analog <= upper_s) |=> (spd_ff == $past(spd_analog[SPD_W-1:0])))
        else $error("analog speed not gain times voltage plus offset");

    // the pwm and torque paths are judged like the analog speed path: inside the
    // limits the scaled command must arrive unchanged one edge later
    a_pwm_speed_scale: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (EXT_SPD_SEL_IN && cfg_ff.ext_pwm && spd_pwm >= lower_s && spd_pwm <= upper_s)
            |=> (spd_ff == $past(spd_pwm_prod[SPD_W+PWM_WIN_BITS-1:PWM_WIN_BITS])))
        else $error("pwm speed not full scale times duty");

    a_pwm_trq_scale: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (EXT_TRQ_SEL_IN && cfg_ff.ext_pwm && trq_pwm <= tmax_s)
            |=> (trq_ff == $past(trq_pwm_prod[TRQ_W+PWM_WIN_BITS-1:PWM_WIN_BITS])))
        else $error("pwm torque not full scale times duty");

    a_trq_analog_scale: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (EXT_TRQ_SEL_IN && !cfg_ff.ext_pwm && !trq_analog[SUM_W-1] && trq_analog <= tmax_s)
            |=> (trq_ff == $past(trq_analog[TRQ_W-1:0]) && !trq_info_ff))
        else $error("analog torque not gain times voltage plus offset");

    a_op_speed_pass: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (!EXT_SPD_SEL_IN && OP_SPEED_IN >= cfg_ff.spd_lower && OP_SPEED_IN <= cfg_ff.spd_upper)
            |=> (spd_ff == $past(OP_SPEED_IN) && !spd_info_ff))
        else $error("in-range speed altered or flagged");

    a_class_b_lower: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        !MOTOR_STOPPED_IN |=> $stable(cfg_ff.spd_lower))
        else $error("lower limit moved while running");

    a_class_c_func: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        !CFG_EXEC_IN |=> $stable(cfg_ff.dout_func))
        else $error("output function moved without execute");

    a_class_a_ofs: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        ##1 cfg_ff.trq_ofs == $past(CFG_IN.trq_ofs))
        else $error("class A offset not applied at once");

endmodule : mcl_limiter
`default_nettype wire

//--- bench/mcl_pwm_src.sv
// partner model: free-running pwm setting source for the external command input
`timescale 1ns/1ps
`default_nettype none
module mcl_pwm_src #(
    parameter int PERIOD = 400,
    parameter int HIGH   = 200
) (
    input  wire logic clk_in,
    output var logic  pwm_out
);
    int cnt = 0;

    // period and high time are whole multiples of the 50-cycle sample step,
    // so every 1024-sample frame sees an exact duty whatever the phase
    always @(negedge clk_in) begin
        cnt     <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        pwm_out <= (cnt < HIGH);
    end
endmodule : mcl_pwm_src
`default_nettype wire

//--- bench/mcl_limiter_tb.sv
// testbench: scenario tasks for the motor command limiter
`timescale 1ns/1ps
`default_nettype none
module mcl_limiter_tb
    import mcl_pkg::*;
;
    logic              clk, rst, stopped, cfg_exec, spd_sel, trq_sel, pwm;
    logic              alarm, move, info, va, spd_pulse, dir, tla;
    logic              spd_info, trq_info, act_pwm;
    mcl_cfg_t          cfg;
    logic [SPD_W-1:0]  op_spd, spd_cmd;
    logic [TRQ_W-1:0]  op_trq, trq_cmd;
    logic [VOLT_W-1:0] an_spd, an_trq;
    logic [DOUT_N-1:0] dout;
    int                mismatches = 0;
    int                n_compared = 0;

    mcl_limiter u_mcl_limiter (
        .CLOCK_IN(clk), .RST_IN(rst), .CFG_IN(cfg), .MOTOR_STOPPED_IN(stopped),
        .CFG_EXEC_IN(cfg_exec), .EXT_SPD_SEL_IN(spd_sel), .EXT_TRQ_SEL_IN(trq_sel),
        .OP_SPEED_IN(op_spd), .OP_TORQUE_IN(op_trq), .ANALOG_SPD_IN(an_spd),
        .ANALOG_TRQ_IN(an_trq), .PWM_IN(pwm), .ALARM_IN(alarm), .MOVE_IN(move),
        .INFO_IN(info), .VA_IN(va), .SPEED_PULSE_IN(spd_pulse), .DIR_IN(dir),
        .TORQUE_LIMITING_ACTIVE_IN(tla), .SPEED_CMD_OUT(spd_cmd),
        .TORQUE_CMD_OUT(trq_cmd), .SPEED_CLAMP_INFO_OUT(spd_info),
        .TORQUE_CLAMP_INFO_OUT(trq_info), .DIGITAL_OUT_0_OUT(dout[0]),
        .DIGITAL_OUT_1_OUT(dout[1]), .DIGITAL_OUT_2_OUT(dout[2]),
        .DIGITAL_OUT_3_OUT(dout[3]), .ACTIVE_EXT_PWM_OUT(act_pwm)
    );

    mcl_pwm_src u_mcl_pwm_src (.clk_in(clk), .pwm_out(pwm));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk

    task automatic outs(input logic [11:0] es, input logic esf, input logic [7:0] et,
                        input logic etf);
        tick(2);
        chk(spd_cmd, es, "speed command");
        chk(12'(spd_info), 12'(esf), "speed clamp flag");
        chk({4'h0, trq_cmd}, {4'h0, et}, "torque command");
        chk(12'(trq_info), 12'(etf), "torque clamp flag");
    endtask : outs

    task automatic run_op(input logic [11:0] s, input logic [7:0] t, input logic [11:0] es,
                          input logic esf, input logic [7:0] et, input logic etf);
        op_spd = s;
        op_trq = t;
        outs(es, esf, et, etf);
    endtask : run_op

    // strobes are held for exactly one edge, then settings have time to land
    task automatic apply(input mcl_cfg_t c, input logic stop, input logic exe);
        cfg      = c;
        stopped  = stop;
        cfg_exec = exe;
        tick(1);
        stopped  = 1'b0;
        cfg_exec = 1'b0;
        tick(3);
    endtask : apply

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_defaults;
        run_op(12'hC4E, 8'hC8, 12'hC4E, 1'b0, 8'hC8, 1'b0);
        run_op(12'hC4F, 8'hC8, 12'hC4E, 1'b1, 8'hC8, 1'b0);
        run_op(12'h04F, 8'hC9, 12'h050, 1'b1, 8'hC8, 1'b1);
        chk(12'(act_pwm), 12'h000, "source after reset");
        alarm     = 1'b1;
        tla       = 1'b1;
        dir       = 1'b1;
        spd_pulse = 1'b0;
        tick(2);
        chk(12'(dout), 12'h00C, "default outputs");
    endtask : t_defaults

    task automatic t_pwm;
        mcl_cfg_t c;
        c         = CFG_DEF;
        c.ext_pwm = 1'b1;
        apply(c, 1'b1, 1'b0);
        chk(12'(act_pwm), 12'h000, "source without execute");
        apply(c, 1'b0, 1'b1);
        chk(12'(act_pwm), 12'h001, "source after execute");
        spd_sel = 1'b1;
        trq_sel = 1'b1;
        outs(12'h050, 1'b1, 8'h00, 1'b0);
        // first duty frame closes about 51200 cycles after reset
        tick(52000);
        outs(12'h627, 1'b0, 8'h64, 1'b0);
    endtask : t_pwm

    task automatic t_limits;
        mcl_cfg_t c;
        spd_sel     = 1'b0;
        trq_sel     = 1'b0;
        c           = CFG_DEF;
        c.ext_pwm   = 1'b1;
        c.spd_upper = 12'h7D0;
        c.spd_lower = 12'h1F4;
        c.trq_max   = 8'h64;
        apply(c, 1'b0, 1'b0);
        run_op(12'h9C4, 8'h96, 12'h9C4, 1'b0, 8'h96, 1'b0);
        apply(c, 1'b1, 1'b0);
        run_op(12'h9C4, 8'h96, 12'h7D0, 1'b1, 8'h64, 1'b1);
        run_op(12'h7D0, 8'h64, 12'h7D0, 1'b0, 8'h64, 1'b0);
        run_op(12'h1F3, 8'h00, 12'h1F4, 1'b1, 8'h00, 1'b0);
        run_op(12'h1F4, 8'h63, 12'h1F4, 1'b0, 8'h63, 1'b0);
    endtask : t_limits

    task automatic t_analog;
        mcl_cfg_t c;
        c = CFG_DEF;
        apply(c, 1'b1, 1'b1);
        chk(12'(act_pwm), 12'h000, "source back to analog");
        spd_sel = 1'b1;
        trq_sel = 1'b1;
        an_spd  = 14'h0800;
        an_trq  = 14'h0800;
        outs(12'h500, 1'b0, 8'h56, 1'b0);
        c.spd_gain = 12'h190;
        c.spd_ofs  = 12'h064;
        c.trq_gain = 8'h15;
        c.trq_ofs  = 8'hFB;
        an_spd     = 14'h0A00;
        an_trq     = 14'h1400;
        apply(c, 1'b0, 1'b0);
        outs(12'h44C, 1'b0, 8'h64, 1'b0);
        // gain 21 over a 5 V span overshoots a 100 % ceiling slightly
        c.trq_max = 8'h64;
        c.trq_ofs = 8'h00;
        c.spd_ofs = 12'hA24;
        apply(c, 1'b1, 1'b0);
        outs(12'h050, 1'b1, 8'h64, 1'b1);
    endtask : t_analog

    task automatic t_dout;
        mcl_cfg_t    c;
        logic [10:0] st;
        logic        prev;
        c         = CFG_DEF;
        c.trq_max = 8'h64;
        prev      = 1'b1;
        spd_sel   = 1'b0;
        trq_sel   = 1'b0;
        op_spd    = 12'h04F;
        op_trq    = 8'h00;
        {alarm, move, info, tla, va, spd_pulse, dir} = 7'b1000110;
        // speed clamped, torque not: info follows the clamp flag
        st = 11'h2D2;
        for (int i = 0; i < FN_COUNT; i++) begin
            c.dout_func[0] = mcl_dout_fn_t'(i);
            c.dout_inv[0]  = i[0];
            apply(c, 1'b1, 1'b0);
            chk(12'(dout[0]), 12'(prev), "output held before execute");
            apply(c, 1'b0, 1'b1);
            prev = st[i] ^ i[0];
            chk(12'(dout[0]), 12'(prev), "output function");
        end
    endtask : t_dout

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial begin
        {rst, stopped, cfg_exec, spd_sel, trq_sel} = 5'b10000;
        {alarm, move, info, va, spd_pulse, dir, tla} = 7'h00;
        cfg    = CFG_DEF;
        op_spd = 12'h3E8;
        op_trq = 8'h64;
        an_spd = 14'h0000;
        an_trq = 14'h0000;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        tick(1);
        t_defaults();
        t_pwm();
        t_limits();
        t_analog();
        t_dout();
        test_done();
    end
endmodule : mcl_limiter_tb
`default_nettype wire
